// ===== pkg/occ_defs.svh
`ifndef OCC_DEFS_SVH
`define OCC_DEFS_SVH

// Register byte offsets on the Avalon slave
`define OCC_OFS_CONTROL    5'h00
`define OCC_OFS_PRIMARY    5'h04
`define OCC_OFS_SECONDARY  5'h08
`define OCC_OFS_COUNT      5'h0C
`define OCC_OFS_PERIOD_A   5'h10
`define OCC_OFS_PERIOD_B   5'h14
`define OCC_OFS_TB_ENABLE  5'h18
`define OCC_OFS_STATUS     5'h1C

// Control register field positions
`define OCC_BIT_IDLE_STOP  13
`define OCC_BIT_FAULT      4
`define OCC_BIT_TSEL       3
`define OCC_MODE_HI        2
`define OCC_MODE_LO        0

// Status register field positions
`define OCC_BIT_FLAG       0
`define OCC_BIT_PIN        1

// Mode field encodings
`define OCC_MODE_OFF       3'h0
`define OCC_MODE_SET_HIGH  3'h1
`define OCC_MODE_SET_LOW   3'h2
`define OCC_MODE_TOGGLE    3'h3
`define OCC_MODE_PULSE_ONE 3'h4
`define OCC_MODE_PULSE_RUN 3'h5
`define OCC_MODE_PWM       3'h6
`define OCC_MODE_PWM_FLT   3'h7

// Reset values and timing counts
`define OCC_RST_WORD16     16'h0000
`define OCC_RST_PERIOD     16'hFFFF
`define OCC_FLAG_DELAY     2

`endif

// ===== pkg/occ_pkg.sv
package occ_pkg;

   typedef logic [15:0] occ_word_t;

   // Time base state
   typedef struct packed {
      occ_word_t count;
   } occ_tb_state_s;

   // Whole channel state
   typedef struct packed {
      logic       idle_stop;
      logic       fault;
      logic       tsel;
      logic [2:0] mode;
      occ_word_t  primary;
      occ_word_t  secondary;
      occ_word_t  period_a;
      occ_word_t  period_b;
      logic [1:0] tb_en;
      logic       pin;
      logic       flag;
      logic       done;
      logic [2:0] mode_prev;
      logic [1:0] ev_pipe;
      logic       ack;
      logic [31:0] rdata;
      logic       flt_meta;
      logic       flt_sync;
   } occ_state_s;

endpackage

// ===== design/occ_time_base.sv
`timescale 1ns/10ps
`include "occ_defs.svh"

module occ_time_base
   import occ_pkg::*;
   #(
   parameter int WIDTH = 16
   )
   (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Control
   input  wire logic             enable,
   input  wire logic [WIDTH-1:0] period,
   // Count
   output      logic [WIDTH-1:0] count
   );

   occ_tb_state_s state_reg;
   occ_tb_state_s state_next;

   always_comb begin
      state_next = state_reg;
      if (enable) begin
         if (state_reg.count == period) begin
            state_next.count = `OCC_RST_WORD16; // see [R13]
         end else begin
            state_next.count = state_reg.count + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign count = state_reg.count;

endmodule

// ===== design/occ_channel.sv
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`include "occ_defs.svh"

// Operation
// [R1] Idle-stop bit halts channel in CPU idle
// [R2] Fault status bit read-only, hardware-cleared
// [R3] Timer select bit picks second/third timer
// [R4] Mode 000 disables all compare events
// [R5] Mode 001: start low, match drives high
// [R6] Mode 010: start high, match drives low
// [R7] Mode 011 toggles pin every match
// [R8] Modes 100/101: single or continuous pulses
// [R9] Modes 110/111: PWM, fault ignored/enabled
// [R10] Match when primary equals selected count
// [R11] Pin changes one clock after match
// [R12] Flag rises two clocks after pin change
// [R13] Time base wraps to zero after period
// [R14] Fault pin chosen by channel group
// [R15] Up to eight identical channels
// [R16] Unimplemented control bits read zero
// [R17] Software disables before changing mode
// [R18] Software enables selected time base
// [R19] Toggle starts low, inverts per match
// [R20] Reset clears control, channel disabled
module occ_channel
   import occ_pkg::*;
   #(
   parameter int CHANNEL_INDEX = 1
   )
   (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Avalon-MM slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output      logic [31:0] avs_readdata,
   output      logic        avs_waitrequest,
   // System
   input  wire logic        cpu_idle,
   // Fault pins
   input  wire logic        fault_input_low_group,
   input  wire logic        fault_input_high_group,
   // Channel outputs
   output      logic        compare_output_pin,
   output      logic        channel_interrupt_flag
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic occ_word_t merge16(input occ_word_t old_val,
                                         input logic [31:0] wdata,
                                         input logic [3:0] be);
      occ_word_t res;
      res = old_val;
      if (be[0]) begin
         res[7:0] = wdata[7:0];
      end
      if (be[1]) begin
         res[15:8] = wdata[15:8];
      end
      return res;
   endfunction

   function automatic logic [31:0] zext16(input occ_word_t v);
      return {16'h0000, v};
   endfunction

   // ----------------------------------------------------------------
   // State and time bases
   // ----------------------------------------------------------------
   occ_state_s state_reg;
   occ_state_s state_next;
   occ_word_t  count_a;
   occ_word_t  count_b;
   occ_word_t  sel_count;
   occ_word_t  sel_period;
   occ_word_t  ctl_word;
   logic       sel_run;
   logic       halt;
   logic       active;
   logic       match_pri;
   logic       match_sec;
   logic       wrap;
   logic       entry;
   logic       pin_evt;
   logic       req;
   logic       wr_take;
   logic       flag_clr;
   logic       fault_pin;

   // Each channel carries its own copy of the whole register set
   occ_time_base #(.WIDTH(16)) u_tb_a ( // see [R15]
      .clk    (clk),
      .rstn   (rstn),
      .enable (state_reg.tb_en[0]),
      .period (state_reg.period_a),
      .count  (count_a)
   );

   occ_time_base #(.WIDTH(16)) u_tb_b (
      .clk    (clk),
      .rstn   (rstn),
      .enable (state_reg.tb_en[1]),
      .period (state_reg.period_b),
      .count  (count_b)
   );

   // Channels one to four watch the low group, the rest the high group
   assign fault_pin = (CHANNEL_INDEX <= 4) ? fault_input_low_group
                                           : fault_input_high_group; // see [R14]

   // ----------------------------------------------------------------
   // Compare datapath
   // ----------------------------------------------------------------
   assign sel_count  = state_reg.tsel ? count_b : count_a;     // see [R3]
   assign sel_period = state_reg.tsel ? state_reg.period_b
                                      : state_reg.period_a;
   // A stopped time base never matches, or a frozen equal count would
   // fire every cycle
   assign sel_run    = state_reg.tsel ? state_reg.tb_en[1]
                                      : state_reg.tb_en[0];    // see [R18]
   assign halt       = cpu_idle & state_reg.idle_stop;         // see [R1]
   assign active     = (state_reg.mode != `OCC_MODE_OFF) & sel_run & ~halt; // see [R4]
   assign match_pri  = active & (sel_count == state_reg.primary); // see [R10]
   assign match_sec  = active & (sel_count == state_reg.secondary);
   assign wrap       = active & (sel_count == sel_period);
   assign entry      = state_reg.mode != state_reg.mode_prev;

   assign ctl_word = {2'h0, state_reg.idle_stop, 8'h00,
                      state_reg.fault, state_reg.tsel,
                      state_reg.mode};                         // see [R16]

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   // One wait state: the request is decoded in its first cycle and
   // completes in the second
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~state_reg.ack;
   assign wr_take         = avs_write & state_reg.ack;
   assign flag_clr        = wr_take & (avs_address == `OCC_OFS_STATUS)
                            & avs_byteenable[0]
                            & avs_writedata[`OCC_BIT_FLAG];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next           = state_reg;
      pin_evt              = 1'b0;
      state_next.ack       = req & ~state_reg.ack;
      state_next.mode_prev = state_reg.mode;
      state_next.flt_meta  = fault_pin;
      state_next.flt_sync  = state_reg.flt_meta;

      // Read data captured in the decode cycle, stands at completion
      if (avs_read & ~state_reg.ack) begin
         if (avs_address == `OCC_OFS_CONTROL) begin
            state_next.rdata = zext16(ctl_word);
         end else if (avs_address == `OCC_OFS_PRIMARY) begin
            state_next.rdata = zext16(state_reg.primary);
         end else if (avs_address == `OCC_OFS_SECONDARY) begin
            state_next.rdata = zext16(state_reg.secondary);
         end else if (avs_address == `OCC_OFS_COUNT) begin
            state_next.rdata = zext16(sel_count);
         end else if (avs_address == `OCC_OFS_PERIOD_A) begin
            state_next.rdata = zext16(state_reg.period_a);
         end else if (avs_address == `OCC_OFS_PERIOD_B) begin
            state_next.rdata = zext16(state_reg.period_b);
         end else if (avs_address == `OCC_OFS_TB_ENABLE) begin
            state_next.rdata = {30'h00000000, state_reg.tb_en};
         end else if (avs_address == `OCC_OFS_STATUS) begin
            state_next.rdata = {30'h00000000, state_reg.pin,
                                state_reg.flag};
         end else begin
            state_next.rdata = 32'h00000000;
         end
      end

      // Register writes; the fault bit has no write path
      if (wr_take) begin
         if (avs_address == `OCC_OFS_CONTROL) begin
            if (avs_byteenable[0]) begin
               state_next.tsel = avs_writedata[`OCC_BIT_TSEL];
               state_next.mode = avs_writedata[`OCC_MODE_HI:`OCC_MODE_LO];
            end
            if (avs_byteenable[1]) begin
               state_next.idle_stop = avs_writedata[`OCC_BIT_IDLE_STOP];
            end
         end else if (avs_address == `OCC_OFS_PRIMARY) begin
            state_next.primary = merge16(state_reg.primary,
                                         avs_writedata, avs_byteenable);
         end else if (avs_address == `OCC_OFS_SECONDARY) begin
            state_next.secondary = merge16(state_reg.secondary,
                                           avs_writedata, avs_byteenable);
         end else if (avs_address == `OCC_OFS_PERIOD_A) begin
            state_next.period_a = merge16(state_reg.period_a,
                                          avs_writedata, avs_byteenable);
         end else if (avs_address == `OCC_OFS_PERIOD_B) begin
            state_next.period_b = merge16(state_reg.period_b,
                                          avs_writedata, avs_byteenable);
         end else if (avs_address == `OCC_OFS_TB_ENABLE) begin
            if (avs_byteenable[0]) begin
               state_next.tb_en = avs_writedata[1:0];
            end
         end
      end

      // Output behaviour; pin is registered, so it moves one clock
      // after the cycle in which the match is seen
      if (entry) begin
         state_next.done = 1'b0;
         state_next.pin  = (state_reg.mode == `OCC_MODE_SET_LOW); // see [R5] see [R6] see [R19]
         if (state_reg.mode != `OCC_MODE_PWM_FLT) begin
            state_next.fault = 1'b0;                           // see [R2]
         end
      end else begin
         case (state_reg.mode)
            `OCC_MODE_SET_HIGH: begin
               if (match_pri & ~state_reg.done) begin
                  state_next.pin  = 1'b1;                      // see [R5] see [R11]
                  state_next.done = 1'b1;
                  pin_evt         = 1'b1;
               end
            end
            `OCC_MODE_SET_LOW: begin
               if (match_pri & ~state_reg.done) begin
                  state_next.pin  = 1'b0;                      // see [R6] see [R11]
                  state_next.done = 1'b1;
                  pin_evt         = 1'b1;
               end
            end
            `OCC_MODE_TOGGLE: begin
               if (match_pri) begin
                  state_next.pin = ~state_reg.pin;             // see [R7] see [R19]
                  pin_evt        = 1'b1;
               end
            end
            `OCC_MODE_PULSE_ONE,
            `OCC_MODE_PULSE_RUN: begin
               // Rise on primary, fall on secondary; single mode stops
               if (match_pri & ~state_reg.pin & ~state_reg.done) begin
                  state_next.pin = 1'b1;                       // see [R8]
               end else if (match_sec & state_reg.pin) begin
                  state_next.pin  = 1'b0;
                  state_next.done = (state_reg.mode == `OCC_MODE_PULSE_ONE);
                  pin_evt         = 1'b1;
               end
            end
            `OCC_MODE_PWM,
            `OCC_MODE_PWM_FLT: begin
               if (wrap) begin
                  state_next.pin = (state_reg.primary != 16'h0000); // see [R9]
                  pin_evt        = 1'b1;
               end else if (match_pri) begin
                  state_next.pin = 1'b0;
               end
               if ((state_reg.mode == `OCC_MODE_PWM_FLT)
                   & state_reg.flt_sync) begin
                  state_next.fault = 1'b1;                     // see [R2] see [R9]
               end
               if (state_next.fault) begin
                  state_next.pin = 1'b0;
               end
            end
            default: begin
               state_next.pin = 1'b0;                          // see [R4]
            end
         endcase
      end

      // Two-stage delay from pin change to flag; set beats clear
      state_next.ev_pipe = {state_reg.ev_pipe[0], pin_evt};
      state_next.flag    = (state_reg.flag & ~flag_clr)
                           | state_reg.ev_pipe[1];             // see [R12]
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg          <= '0;                             // see [R20]
         state_reg.period_a <= `OCC_RST_PERIOD;
         state_reg.period_b <= `OCC_RST_PERIOD;
      end else begin
         state_reg <= state_next;
      end
   end

   assign avs_readdata           = state_reg.rdata;
   assign compare_output_pin     = state_reg.pin;
   assign channel_interrupt_flag = state_reg.flag;

endmodule

// ===== test/occ_channel_chk.sv
`timescale 1ns/10ps
`include "occ_defs.svh"
module occ_channel_chk
   import occ_pkg::*;
   (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // Bus
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Channel outputs
   input wire logic        compare_output_pin,
   input wire logic        channel_interrupt_flag
   );
   logic [2:0] mode_reg;
   logic [2:0] age_reg;
   logic       pin;
   logic       flg;
   logic       ctl;
   logic       sngl;
   assign pin = compare_output_pin;
   assign flg = channel_interrupt_flag;
   assign ctl = !avs_waitrequest && avs_address == `OCC_OFS_CONTROL;
   // Age masks the cycles of mode entry, where the pin may jump
   assign sngl = mode_reg inside {3'h1, 3'h2, 3'h3} && age_reg >= 3'h3;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_reg <= 3'h0;
         age_reg  <= 3'h7;
      end
      else if (ctl && avs_write && avs_byteenable[0]) begin
         mode_reg <= avs_writedata[2:0];
         age_reg  <= 3'h0;
      end
      else if (age_reg != 3'h7) begin
         age_reg <= age_reg + 3'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_wait;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("bus answer late");
   property p_flag_late;
      sngl && $rose(flg) |-> $past(pin, 2) != $past(pin, 3);
   endproperty
   a_flag_late: assert property (p_flag_late) else $error("flag early");
   property p_pin_flag;
      sngl && $changed(pin) |-> ##2 flg;
   endproperty
   a_pin_flag: assert property (p_pin_flag) else $error("flag missing");
   property p_hold_high;
      mode_reg == 3'h1 && age_reg >= 3'h3 && $past(pin) |-> pin;
   endproperty
   a_hold_high: assert property (p_hold_high) else $error("pin fell");
   property p_hold_low;
      mode_reg == 3'h2 && age_reg >= 3'h3 && !$past(pin) |-> !pin;
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("pin rose");
   property p_off;
      mode_reg == 3'h0 && age_reg >= 3'h3 |-> !pin && !$rose(flg);
   endproperty
   a_off: assert property (p_off) else $error("event while off");
   property p_unimpl;
      ctl && avs_read |-> avs_readdata[15:14] == 2'h0
         && avs_readdata[12:5] == 8'h00;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("bits not 0");
   property p_fault_ro;
      ctl && avs_read && mode_reg != 3'h7 && age_reg >= 3'h3
         |-> !avs_readdata[4];
   endproperty
   a_fault_ro: assert property (p_fault_ro) else $error("fault set");
   property p_reset;
      disable iff (1'b0) !rstn |-> !pin && !flg;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state");
   c_high: cover property (mode_reg == 3'h1 && $rose(pin));
   c_low: cover property (mode_reg == 3'h2 && $fell(pin));
   c_tog: cover property (mode_reg == 3'h3 && $rose(flg));
endmodule

bind occ_channel occ_channel_chk occ_channel_chk_i (
   .clk(clk), .rstn(rstn), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .compare_output_pin(compare_output_pin),
   .channel_interrupt_flag(channel_interrupt_flag));

// ===== test/occ_pin_model.sv
`timescale 1ns/10ps
module occ_pin_model
   (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Observed pin
   input  wire logic compare_output_pin,
   // Edge records
   output int        n_chg,
   output int        n_rise,
   output int        t_last
   );
   int   cyc;
   logic pin_d;
   // Stamps in cycles, so gaps compare straight to periods
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cyc    <= 0;
         n_chg  <= 0;
         n_rise <= 0;
         t_last <= 0;
         pin_d  <= 1'b0;
      end
      else begin
         cyc   <= cyc + 1;
         pin_d <= compare_output_pin;
         if (compare_output_pin !== pin_d) begin
            n_chg  <= n_chg + 1;
            t_last <= cyc;
            n_rise <= n_rise + int'(compare_output_pin);
         end
      end
   end
endmodule

// ===== test/occ_channel_tb.sv
`timescale 1ns/10ps
`include "occ_defs.svh"
module occ_channel_tb
   import occ_pkg::*;
   ;
   logic        clk = 1'b0;
   logic        rstn;
   logic [4:0]  adr = 5'h00;
   logic        rd_q = 1'b0;
   logic        wr_q = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] avs_readdata;
   logic        wait_q;
   logic        idle = 1'b0;
   logic        flo = 1'b0;
   logic        fhi = 1'b0;
   logic        pin;
   logic        flag;
   logic [31:0] rd;
   int          n_errors = 0;
   int          comparisons = 0;
   int          n_chg, n_rise, t_last, p, t1, t2, n0;
   occ_channel occ_channel_i (.clk(clk), .rstn(rstn), .avs_address(adr),
      .avs_read(rd_q), .avs_write(wr_q), .avs_writedata(wd),
      .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
      .avs_waitrequest(wait_q), .cpu_idle(idle),
      .fault_input_low_group(flo), .fault_input_high_group(fhi),
      .compare_output_pin(pin), .channel_interrupt_flag(flag));
   occ_pin_model occ_pin_model_i (.clk(clk), .rstn(rstn),
      .compare_output_pin(pin), .n_chg(n_chg), .n_rise(n_rise),
      .t_last(t_last));
   always #4 clk = ~clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t seen %0h want %0h", $time, seen, exp);
      end
   endtask
   // Request held until the edge that samples waitrequest low
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [15:0] d);
      int k;
      logic ok;
      k = 0;
      @(posedge clk);
      adr <= a;
      wd <= {16'h0000, d};
      wr_q <= w;
      rd_q <= !w;
      // Answer sampled mid-cycle, where it is settled; it stands through
      // the rising edge that follows
      do begin
         @(negedge clk);
         ok = (wait_q === 1'b0);
         rd = avs_readdata;
         @(posedge clk);
         k++;
      end while (!ok && k < 50);
      if (!ok) begin
         n_errors++;
      end
      wr_q <= 1'b0;
      rd_q <= 1'b0;
   endtask
   task automatic w(input logic [4:0] a, input logic [15:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic r(input logic [4:0] a, input logic [15:0] e);
      bus(1'b0, a, 16'h0000);
      chk(rd, {16'h0000, e});
   endtask
   task automatic wait_chg(output int t);
      int k;
      k = 0;
      n0 = n_chg;
      while (n_chg == n0 && k < 3000) begin
         @(posedge clk);
         k++;
      end
      chk(32'(k < 3000), 32'h1);
      t = t_last;
   endtask
   task automatic quiet(input int n);
      n0 = n_chg;
      repeat (n) @(posedge clk);
      chk(32'(n_chg), 32'(n0));
   endtask
   task automatic end_sim();
      if (n_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end
      else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #400000;
      n_errors++;
      end_sim();
   end
   initial begin
      rstn = 1'b0;
      rd = $urandom(32'hA4931536);
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      r(`OCC_OFS_CONTROL, 16'h0000);
      r(`OCC_OFS_STATUS, 16'h0000);
      w(`OCC_OFS_CONTROL, 16'hFFFF);
      r(`OCC_OFS_CONTROL, 16'h200F);
      // Periods only grow: a count above a new period would run to wrap
      for (int i = 1; i < 4; i++) begin
         p = 8 * i + $urandom_range(7);
         w(`OCC_OFS_CONTROL, 16'h0000);
         w(`OCC_OFS_TB_ENABLE, 16'h0000);
         w(`OCC_OFS_PERIOD_A, p[15:0]);
         w(`OCC_OFS_PRIMARY, 16'($urandom_range(p)));
         w(`OCC_OFS_CONTROL, 16'h0003);
         chk({31'h0, pin}, 32'h0);
         w(`OCC_OFS_TB_ENABLE, 16'h0001);
         wait_chg(t1);
         wait_chg(t2);
         chk(32'(t2 - t1), 32'(p + 1));
      end
      w(`OCC_OFS_PERIOD_A, 16'h0028);
      w(`OCC_OFS_PRIMARY, 16'h0007);
      for (int m = 1; m < 3; m++) begin
         w(`OCC_OFS_CONTROL, 16'h0000);
         w(`OCC_OFS_TB_ENABLE, 16'h0000);
         repeat (4) @(posedge clk);
         w(`OCC_OFS_STATUS, 16'h0001);
         w(`OCC_OFS_CONTROL, 16'(m));
         repeat (3) @(posedge clk);
         chk({31'h0, pin}, 32'(m == 2));
         chk({31'h0, flag}, 32'h0);
         quiet(100);
         w(`OCC_OFS_TB_ENABLE, 16'h0001);
         wait_chg(t1);
         chk({31'h0, pin}, 32'(m == 1));
         repeat (3) @(posedge clk);
         chk({31'h0, flag}, 32'h1);
         quiet(100);
         w(`OCC_OFS_STATUS, 16'h0001);
         @(posedge clk);
         chk({31'h0, flag}, 32'h0);
      end
      w(`OCC_OFS_CONTROL, 16'h0000);
      w(`OCC_OFS_PRIMARY, 16'h0029);
      w(`OCC_OFS_CONTROL, 16'h0003);
      quiet(130);
      w(`OCC_OFS_PRIMARY, 16'h0005);
      w(`OCC_OFS_CONTROL, 16'h000B);
      quiet(130);
      w(`OCC_OFS_PERIOD_B, 16'h0013);
      w(`OCC_OFS_TB_ENABLE, 16'h0003);
      wait_chg(t1);
      wait_chg(t2);
      chk(32'(t2 - t1), 32'h14);
      w(`OCC_OFS_CONTROL, 16'h2003);
      idle <= 1'b1;
      repeat (3) @(posedge clk);
      quiet(130);
      w(`OCC_OFS_CONTROL, 16'h0003);
      wait_chg(t1);
      idle <= 1'b0;
      w(`OCC_OFS_CONTROL, 16'h0000);
      repeat (4) @(posedge clk);
      w(`OCC_OFS_STATUS, 16'h0001);
      quiet(130);
      chk({31'h0, flag}, 32'h0);
      w(`OCC_OFS_SECONDARY, 16'h0014);
      r(`OCC_OFS_SECONDARY, 16'h0014);
      for (int m = 4; m < 6; m++) begin
         w(`OCC_OFS_CONTROL, 16'h0000);
         n0 = n_rise;
         w(`OCC_OFS_CONTROL, 16'(m));
         repeat (200) @(posedge clk);
         chk(32'(m == 4 ? n_rise - n0 : int'(n_rise - n0 >= 4)), 32'h1);
      end
      w(`OCC_OFS_CONTROL, 16'h0006);
      flo <= 1'b1;
      repeat (8) @(posedge clk);
      r(`OCC_OFS_CONTROL, 16'h0006);
      w(`OCC_OFS_CONTROL, 16'h0000);
      flo <= 1'b0;
      fhi <= 1'b1;
      w(`OCC_OFS_CONTROL, 16'h0007);
      repeat (8) @(posedge clk);
      r(`OCC_OFS_CONTROL, 16'h0007);
      flo <= 1'b1;
      repeat (8) @(posedge clk);
      r(`OCC_OFS_CONTROL, 16'h0017);
      chk({31'h0, pin}, 32'h0);
      flo <= 1'b0;
      fhi <= 1'b0;
      w(`OCC_OFS_CONTROL, 16'h0000);
      r(`OCC_OFS_CONTROL, 16'h0000);
      end_sim();
   end
endmodule
